// ===== logic/asp_baud_gen.sv
// baud tick generator: prescaled main clock or external baud pin
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_baud_gen (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] ps_code,
  input  wire logic       ext_clk,
  output logic            tick
);
  import asp_pkg::*;
  asp_bg_state_t st_ff;
  asp_bg_state_t nxt_st;
  logic [8:0]    mask9;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.tick     = 1'b0;
    nxt_st.ext_prev = ext_clk;
    mask9 = (9'h001 << ({1'b0, ps_code[2:0]} + 4'h1)) - 9'h001;
    if (!run) begin
      nxt_st.div = 8'h00;
    end else if (ps_code == `ASP_PS_EXT) begin
      // one tick per external rising edge, sixteen ticks per bit
      nxt_st.tick = ext_clk & ~st_ff.ext_prev;
    end else if (ps_code < `ASP_PS_EXT) begin
      // tick every 2^(n+1) clocks, sixteen ticks make one bit
      nxt_st.div  = st_ff.div + 8'h01;
      nxt_st.tick = ((st_ff.div & mask9[7:0]) == mask9[7:0]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

  idle_no_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!run || (ps_code > `ASP_PS_EXT)) |=> !tick)
    else $error("baud tick while stopped or prohibited code");
  div_period_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    // dropping run clears the divider, so the period holds only while it stays up
    (run && ps_code == 4'h1 && tick) ##1 (run && ps_code == 4'h1)[*3] |=> tick)
    else $error("prescale period of four clocks not kept");
endmodule // asp_baud_gen

// ===== logic/asp_serial.sv
// serial port: mode registers, baud selection and uart framing over apb
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_serial (
  input  wire logic          CORE_CLK,
  input  wire logic          RESETN,
  input  asp_pkg::asp_apb_req_t  APB_REQ,
  output asp_pkg::asp_apb_rsp_t  APB_RSP,
  input  asp_pkg::asp_pins_in_t  PINS_IN,
  output asp_pkg::asp_pins_out_t PINS_OUT,
  output asp_pkg::asp_csi_ctrl_t CSI_CTRL
);
  import asp_pkg::*;
  logic       rst_meta_ff;
  logic       rst_n_ff;
  asp_state_t st_ff;
  asp_state_t nxt_st;
  logic       tick;
  logic       uart_on;
  logic       tx_on;
  logic       rx_on;
  logic       csi_on;
  logic       stopped;
  logic       bg_run;
  logic       addr_ok;
  logic [15:0] idx;
  logic       hit;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] rmux;
  logic [1:0] par_mode;
  logic       char8;
  logic [7:0] tx_load;
  logic [7:0] rx_word;
  logic [2:0] last_bit;

  // reset released through two flops, asserted at once
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // mode decode; uart wins if software sets both kinds of enable
  assign tx_on   = st_ff.async_mode[`ASP_AM_TX_EN];
  assign rx_on   = st_ff.async_mode[`ASP_AM_RX_EN];
  assign uart_on = tx_on | rx_on;
  assign csi_on  = st_ff.sync_mode[`ASP_SM_3W_EN] & ~uart_on;
  assign stopped = ~uart_on & ~csi_on;
  assign bg_run  = uart_on | (csi_on & st_ff.sync_mode[`ASP_SM_INT_CLK]);
  assign par_mode = st_ff.async_mode[5:4];
  assign char8    = st_ff.async_mode[`ASP_AM_CHAR8];
  assign last_bit = char8 ? `ASP_BIT_LAST8 : `ASP_BIT_LAST7;

  asp_baud_gen u_baud (
    .core_clk (CORE_CLK),
    .rst_n    (rst_n_ff),
    .run      (bg_run),
    .ps_code  (st_ff.baud_div[7:4]),
    .ext_clk  (PINS_IN.sck),
    .tick     (tick)
  );

  // register index sits in paddr[17:2]; anything above must be zero
  assign idx     = APB_REQ.paddr[17:2];
  assign addr_ok = (APB_REQ.paddr[31:18] == 14'h0000) && (APB_REQ.paddr[1:0] == 2'h0);
  assign hit = addr_ok && (idx >= `ASP_IDX_ASYNC_MODE) && (idx <= `ASP_IDX_STATUS);
  assign acc = APB_REQ.psel & APB_REQ.penable;
  assign wr  = acc & APB_REQ.pwrite & hit;
  assign rd  = acc & ~APB_REQ.pwrite & hit;

  // seven-bit characters drop bit 7 before sending
  assign tx_load = char8 ? APB_REQ.pwdata[7:0] : {1'b0, APB_REQ.pwdata[6:0]};
  // seven-bit frames land in the upper bits of the shifter
  assign rx_word = char8 ? st_ff.rx_sh : {1'b0, st_ff.rx_sh[7:1]};

  always_comb begin
    case (idx)
      `ASP_IDX_ASYNC_MODE: rmux = st_ff.async_mode;
      `ASP_IDX_RX_ERR:     rmux = {5'h00, st_ff.rx_err};
      `ASP_IDX_SYNC_MODE:  rmux = st_ff.sync_mode;
      `ASP_IDX_BAUD_DIV:   rmux = st_ff.baud_div;
      `ASP_IDX_RX_DATA:    rmux = st_ff.rx_data;
      `ASP_IDX_STATUS:     rmux = {4'h0, csi_on, stopped, st_ff.rx_full,
                                   st_ff.tx_st != ASP_IDLE};
      default:             rmux = 8'h00;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // read data is captured in the setup phase so prdata comes from a flop
    if (APB_REQ.psel && !APB_REQ.penable) begin
      nxt_st.rdata = {24'h00_0000, hit ? rmux : 8'h00};
    end
    // reserved bits are forced to zero on write
    if (wr && idx == `ASP_IDX_ASYNC_MODE) begin
      nxt_st.async_mode = APB_REQ.pwdata[7:0] & `ASP_AM_MASK;
    end
    if (wr && idx == `ASP_IDX_SYNC_MODE) begin
      nxt_st.sync_mode = APB_REQ.pwdata[7:0] & `ASP_SM_MASK;
    end
    if (wr && idx == `ASP_IDX_BAUD_DIV) begin
      nxt_st.baud_div = APB_REQ.pwdata[7:0] & `ASP_BD_MASK;
    end
    // clear-on-read first; hardware events below override it
    if (rd && idx == `ASP_IDX_RX_ERR) begin
      nxt_st.rx_err = 3'h0;
    end
    if (rd && idx == `ASP_IDX_RX_DATA) begin
      nxt_st.rx_full = 1'b0;
    end

    // transmitter; a write while busy is dropped
    if (!tx_on) begin
      nxt_st.tx_st = ASP_IDLE;
      nxt_st.txd   = 1'b1;
    end else begin
      case (st_ff.tx_st)
        ASP_IDLE: begin
          nxt_st.txd = 1'b1;
          if (wr && idx == `ASP_IDX_TX_DATA) begin
            nxt_st.tx_st  = ASP_START;
            nxt_st.txd    = 1'b0;
            nxt_st.tx_sh  = tx_load;
            nxt_st.tx_sub = 4'h0;
            nxt_st.tx_bit = 3'h0;
            // zero parity code leaves the bit low
            nxt_st.tx_par = (par_mode == `ASP_PAR_ODD)  ? ~^tx_load :
                            (par_mode == `ASP_PAR_EVEN) ?  ^tx_load : 1'b0;
          end
        end
        ASP_START, ASP_DATA, ASP_PAR, ASP_STOP: begin
          if (tick) begin
            nxt_st.tx_sub = st_ff.tx_sub + 4'h1;
          end
          if (tick && st_ff.tx_sub == `ASP_TICK_LAST) begin
            case (st_ff.tx_st)
              ASP_START: begin
                nxt_st.tx_st = ASP_DATA;
                nxt_st.txd   = st_ff.tx_sh[0];
                nxt_st.tx_sh = {1'b0, st_ff.tx_sh[7:1]};
              end
              ASP_DATA: begin
                if (st_ff.tx_bit != last_bit) begin
                  nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
                  nxt_st.txd    = st_ff.tx_sh[0];
                  nxt_st.tx_sh  = {1'b0, st_ff.tx_sh[7:1]};
                end else if (par_mode == `ASP_PAR_NONE) begin
                  nxt_st.tx_st    = ASP_STOP;
                  nxt_st.txd      = 1'b1;
                  nxt_st.tx_stops = st_ff.async_mode[`ASP_AM_STOP2];
                end else begin
                  nxt_st.tx_st = ASP_PAR;
                  nxt_st.txd   = st_ff.tx_par;
                end
              end
              ASP_PAR: begin
                nxt_st.tx_st    = ASP_STOP;
                nxt_st.txd      = 1'b1;
                nxt_st.tx_stops = st_ff.async_mode[`ASP_AM_STOP2];
              end
              default: begin
                // second stop bit when two were asked
                if (st_ff.tx_stops) begin
                  nxt_st.tx_stops = 1'b0;
                end else begin
                  nxt_st.tx_st = ASP_IDLE;
                end
              end
            endcase
          end
        end
        default: begin
          nxt_st.tx_st = ASP_IDLE;
          nxt_st.txd   = 1'b1;
        end
      endcase
    end

    // receiver; sixteen ticks per bit, start checked at tick 8
    if (!rx_on) begin
      nxt_st.rx_st = ASP_IDLE;
    end else begin
      case (st_ff.rx_st)
        ASP_IDLE: begin
          if (!PINS_IN.rxd) begin
            nxt_st.rx_st  = ASP_START;
            nxt_st.rx_sub = 4'h0;
          end
        end
        ASP_START: begin
          if (tick) begin
            nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
            // a glitch shorter than half a bit is not a start
            if (st_ff.rx_sub == `ASP_TICK_MID) begin
              nxt_st.rx_st  = PINS_IN.rxd ? ASP_IDLE : ASP_DATA;
              nxt_st.rx_sub = 4'h0;
              nxt_st.rx_bit = 3'h0;
            end
          end
        end
        ASP_DATA, ASP_PAR, ASP_STOP: begin
          if (tick) begin
            nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
          end
          if (tick && st_ff.rx_sub == `ASP_TICK_LAST) begin
            case (st_ff.rx_st)
              ASP_DATA: begin
                nxt_st.rx_sh  = {PINS_IN.rxd, st_ff.rx_sh[7:1]};
                nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
                if (st_ff.rx_bit == last_bit) begin
                  nxt_st.rx_st = (par_mode == `ASP_PAR_NONE) ? ASP_STOP : ASP_PAR;
                end
              end
              ASP_PAR: begin
                nxt_st.rx_par = PINS_IN.rxd;
                nxt_st.rx_st  = ASP_STOP;
              end
              default: begin
                // only the first stop bit is looked at
                nxt_st.rx_st   = ASP_IDLE;
                nxt_st.rx_data = rx_word;
                nxt_st.rx_full = 1'b1;
                if (st_ff.rx_full) begin
                  nxt_st.rx_err[`ASP_ERR_OVERRUN] = 1'b1;
                end
                if (!PINS_IN.rxd) begin
                  nxt_st.rx_err[`ASP_ERR_FRAMING] = 1'b1;
                end
                // zero-parity mode never
                if ((par_mode == `ASP_PAR_ODD && !(^rx_word ^ st_ff.rx_par)) ||
                    (par_mode == `ASP_PAR_EVEN && (^rx_word ^ st_ff.rx_par))) begin
                  nxt_st.rx_err[`ASP_ERR_PARITY] = 1'b1;
                end
              end
            endcase
          end
        end
        default: nxt_st.rx_st = ASP_IDLE;
      endcase
    end

    // three-wire internal shift clock toggles on each baud tick
    if (csi_on && st_ff.sync_mode[`ASP_SM_INT_CLK]) begin
      if (tick) begin
        nxt_st.sck = ~st_ff.sck;
      end
    end else begin
      nxt_st.sck = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff            <= '0;
      st_ff.async_mode <= `ASP_RST_BYTE;
      st_ff.sync_mode  <= `ASP_RST_BYTE;
      st_ff.baud_div   <= `ASP_RST_BYTE;
      st_ff.tx_st      <= ASP_IDLE;
      st_ff.rx_st      <= ASP_IDLE;
      st_ff.txd        <= 1'b1;
      st_ff.sck        <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero-wait slave; unmapped or misaligned addresses get pslverr
  assign APB_RSP.prdata  = st_ff.rdata;
  assign APB_RSP.pready  = 1'b1;
  assign APB_RSP.pslverr = acc & ~hit;

  // stopped mode releases every pin to the port logic
  assign PINS_OUT.txd    = st_ff.txd;
  assign PINS_OUT.txd_oe = tx_on;
  assign PINS_OUT.sck    = st_ff.sck;
  assign PINS_OUT.sck_oe = csi_on & st_ff.sync_mode[`ASP_SM_INT_CLK];

  // shift engine outside reads these
  assign CSI_CTRL.enable    = csi_on;
  assign CSI_CTRL.int_clk   = st_ff.sync_mode[`ASP_SM_INT_CLK];
  assign CSI_CTRL.lsb_first = st_ff.sync_mode[`ASP_SM_LSB];
  assign CSI_CTRL.stopped   = stopped;

  reset_modes_a: assert property (@(posedge CORE_CLK)
    $rose(rst_n_ff) |-> (st_ff.async_mode == 8'h00) && (st_ff.sync_mode == 8'h00))
    else $error("mode registers not cleared by reset");
  stopped_pins_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
    stopped |-> !PINS_OUT.txd_oe && !PINS_OUT.sck_oe && !CSI_CTRL.enable)
    else $error("pin driven in stopped mode");
  start_low_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
    (st_ff.tx_st == ASP_START) |-> !st_ff.txd)
    else $error("start bit not low");
  zero_parity_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
    (st_ff.tx_st == ASP_PAR && par_mode == `ASP_PAR_ZERO) |-> !st_ff.txd)
    else $error("zero parity bit sent high");
  rx_char7_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
    ($rose(st_ff.rx_full) && !char8 && $stable(char8)) |-> !st_ff.rx_data[7])
    else $error("seven-bit receive bit 7 not zero");
  framing_flag_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
    (rx_on && st_ff.rx_st == ASP_STOP && tick && st_ff.rx_sub == `ASP_TICK_LAST
     && !PINS_IN.rxd) |=> st_ff.rx_err[`ASP_ERR_FRAMING] && st_ff.rx_full)
    else $error("missing stop bit not flagged");
  stop_two_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
    (tx_on && st_ff.tx_st == ASP_STOP && st_ff.tx_stops && tick
     && st_ff.tx_sub == `ASP_TICK_LAST) |=> (st_ff.tx_st == ASP_STOP) && st_ff.txd)
    else $error("second stop bit dropped");
  int_sck_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
    (csi_on && st_ff.sync_mode[`ASP_SM_INT_CLK] && tick && $stable(st_ff.sync_mode))
    |=> st_ff.sck != $past(st_ff.sck))
    else $error("internal shift clock did not toggle");
endmodule // asp_serial

// ===== pkg/asp_pkg.sv
// types shared by the serial port design
package asp_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } asp_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } asp_apb_rsp_t;
  typedef struct packed {
    logic rxd;
    logic sck;
  } asp_pins_in_t;
  typedef struct packed {
    logic txd;
    logic txd_oe;
    logic sck;
    logic sck_oe;
  } asp_pins_out_t;
  typedef struct packed {
    logic enable;
    logic int_clk;
    logic lsb_first;
    logic stopped;
  } asp_csi_ctrl_t;
  typedef enum logic [4:0] {
    ASP_IDLE  = 5'b0_0001,
    ASP_START = 5'b0_0010,
    ASP_DATA  = 5'b0_0100,
    ASP_PAR   = 5'b0_1000,
    ASP_STOP  = 5'b1_0000
  } asp_fsm_t;
  typedef struct packed {
    logic [7:0] div;
    logic       ext_prev;
    logic       tick;
  } asp_bg_state_t;
  typedef struct packed {
    logic [7:0]  async_mode;
    logic [7:0]  sync_mode;
    logic [7:0]  baud_div;
    logic [2:0]  rx_err;
    logic [7:0]  rx_data;
    logic        rx_full;
    logic [31:0] rdata;
    asp_fsm_t    tx_st;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_sub;
    logic [2:0]  tx_bit;
    logic        tx_par;
    logic        tx_stops;
    logic        txd;
    asp_fsm_t    rx_st;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_sub;
    logic [2:0]  rx_bit;
    logic        rx_par;
    logic        sck;
  } asp_state_t;
endpackage

// ===== pkg/asp_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
`define ASP_IDX_ASYNC_MODE 16'hFF70
`define ASP_IDX_RX_ERR     16'hFF71
`define ASP_IDX_SYNC_MODE  16'hFF72
`define ASP_IDX_BAUD_DIV   16'hFF73
`define ASP_IDX_TX_DATA    16'hFF74
`define ASP_IDX_RX_DATA    16'hFF75
`define ASP_IDX_STATUS     16'hFF76
`define ASP_RST_BYTE       8'h00
`define ASP_AM_MASK        8'hFC
`define ASP_SM_MASK        8'h86
`define ASP_BD_MASK        8'hF0
`define ASP_AM_TX_EN       7
`define ASP_AM_RX_EN       6
`define ASP_AM_CHAR8       3
`define ASP_AM_STOP2       2
`define ASP_SM_3W_EN       7
`define ASP_SM_LSB         2
`define ASP_SM_INT_CLK     1
`define ASP_ERR_PARITY     2
`define ASP_ERR_FRAMING    1
`define ASP_ERR_OVERRUN    0
`define ASP_PAR_NONE       2'h0
`define ASP_PAR_ZERO       2'h1
`define ASP_PAR_ODD        2'h2
`define ASP_PAR_EVEN       2'h3
`define ASP_PS_EXT         4'h8
`define ASP_TICK_LAST      4'hF
`define ASP_TICK_MID       4'h7
`define ASP_BIT_LAST7      3'h6
`define ASP_BIT_LAST8      3'h7
`endif

// ===== verification/asp_peer.sv
// remote serial peer: drives frames onto rxd and captures frames from the line
`timescale 1ns/1ps
module asp_peer #(
  parameter int BIT_CYC = 32
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      rxd
);
  initial rxd = 1'b1;
  // start bit, then n bits lsb first; line idles high after
  task automatic send(input logic [11:0] bits, input int n);
    // changes land right after a core clock edge, like every other input
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // mid-cell sampling of n bits after the start edge
  task automatic grab(input int n, output logic [11:0] bits);
    bits = '0;
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      bits[i] = line_in;
    end
  endtask
endmodule // asp_peer

// ===== verification/tb_async_serial_port_baud_and_modes.sv
// self-checking bench for the serial port: modes, framing and baud rates
`timescale 1ns/1ps
`include "asp_regs.svh"
module tb_async_serial_port_baud_and_modes;
  import asp_pkg::*;
  logic          core_clk    = 1'b0;
  logic          resetn      = 1'b0;
  asp_apb_req_t  req         = '0;
  asp_apb_rsp_t  rsp;
  asp_pins_in_t  pins_in;
  asp_pins_out_t pins_out;
  asp_csi_ctrl_t csi;
  logic          peer_rxd;
  logic          line;
  logic          ext_sck     = 1'b0;
  logic          ext_on      = 1'b0;
  logic [4:0]    ext_cnt     = 5'h00;
  logic [31:0]   rd;
  logic          err;
  int            bad_count   = 0;
  int            checks_done = 0;

  always #25 core_clk = ~core_clk;
  assign pins_in.rxd = peer_rxd;
  assign pins_in.sck = ext_sck;
  // line pulled up while txd is not driven
  assign line = pins_out.txd_oe ? pins_out.txd : 1'b1;

  asp_serial uut (
    .CORE_CLK(core_clk),
    .RESETN  (resetn),
    .APB_REQ (req),
    .APB_RSP (rsp),
    .PINS_IN (pins_in),
    .PINS_OUT(pins_out),
    .CSI_CTRL(csi)
  );
  asp_peer #(.BIT_CYC(32)) peer (.clk(core_clk), .line_in(line), .rxd(peer_rxd));

  // external baud clock, 500 kHz, runs only while that scenario is on
  always @(posedge core_clk) begin
    if (ext_on) begin
      ext_cnt <= (ext_cnt == 5'h13) ? 5'h00 : ext_cnt + 5'h01;
      if (ext_cnt == 5'h13) begin
        ext_sck <= ~ext_sck;
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // idle edge first, so a release and a new setup never share a time step
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge core_clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {14'h0000, idx, 2'b00};
    req.pwdata  <= {24'h00_0000, wd};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h00_0000, exp});
  endtask

  task automatic wait_txd(input logic v);
    do @(posedge core_clk); while (pins_out.txd !== v);
  endtask

  task automatic test_modes();
    logic s;
    rdc(`ASP_IDX_ASYNC_MODE, `ASP_RST_BYTE);
    rdc(`ASP_IDX_SYNC_MODE, `ASP_RST_BYTE);
    rdc(`ASP_IDX_STATUS, 8'h04);
    check({30'h0, pins_out.txd_oe, pins_out.sck_oe}, 32'h0);
    check({31'h0, pins_out.sck}, 32'h1);
    wr(`ASP_IDX_SYNC_MODE, 8'h86);
    @(posedge core_clk);
    check({28'h0, csi}, 32'h0000_000E);
    check({31'h0, pins_out.sck_oe}, 32'h1);
    rdc(`ASP_IDX_STATUS, 8'h08);
    // steady toggling by now: a tick every two clocks flips the shift clock
    s = pins_out.sck;
    repeat (2) @(posedge core_clk);
    check({31'h0, pins_out.sck}, {31'h0, ~s});
    wr(`ASP_IDX_SYNC_MODE, 8'h84);
    @(posedge core_clk);
    check({27'h0, csi, pins_out.sck_oe}, 32'h0000_0014);
    wr(`ASP_IDX_SYNC_MODE, 8'h00);
    @(posedge core_clk);
    check({28'h0, csi}, 32'h1);
    wr(`ASP_IDX_ASYNC_MODE, 8'h80);
    @(posedge core_clk);
    check({27'h0, csi, pins_out.txd_oe}, 32'h1);
    wr(`ASP_IDX_ASYNC_MODE, 8'h00);
    @(posedge core_clk);
    check({28'h0, csi}, 32'h1);
    // unmapped index answers with an error
    apb(1'b0, 16'hFF78, 8'h00);
    check({31'h0, err}, 32'h1);
  endtask

  // every parity code, both lengths, both stop counts; 0xB5 has odd weight
  task automatic test_tx();
    logic [7:0]  am [5] = '{8'h88, 8'h9C, 8'hA8, 8'hBC, 8'hA4};
    logic [11:0] bits;
    logic [11:0] exp;
    logic [7:0]  d;
    int          n;
    foreach (am[k]) begin
      wr(`ASP_IDX_ASYNC_MODE, am[k]);
      d   = am[k][3] ? 8'hB5 : 8'h35;
      n   = am[k][3] ? 8 : 7;
      exp = {4'h0, d};
      case (am[k][5:4])
        2'h1: exp[n] = 1'b0;
        2'h2: exp[n] = ~^d;
        2'h3: exp[n] = ^d;
        default: ;
      endcase
      if (am[k][5:4] != 2'h0) begin
        n++;
      end
      exp[n]     = 1'b1;
      exp[n + 1] = 1'b1;
      wr(`ASP_IDX_TX_DATA, 8'hB5);
      peer.grab(n + 2, bits);
      check({20'h0, bits}, {20'h0, exp});
      // sampled mid second stop slot: busy only with two stops
      rdc(`ASP_IDX_STATUS, {7'h00, am[k][2]});
      repeat (40) @(posedge core_clk);
      wr(`ASP_IDX_ASYNC_MODE, 8'h00);
    end
  endtask

  // framing error case stays last: its low stop may look like a new start
  task automatic test_rx();
    logic [7:0]  am [6] = '{8'h78, 8'h68, 8'h58, 8'h40, 8'h4C, 8'h48};
    logic [11:0] tx [6] = '{12'h2C3, 12'h2C3, 12'h33C, 12'h0FF, 12'h111, 12'h0A5};
    int          nb [6] = '{10, 10, 10, 8, 9, 9};
    logic [7:0]  xd [6] = '{8'hC3, 8'hC3, 8'h3C, 8'h7F, 8'h22, 8'hA5};
    logic [2:0]  xe [6] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h1, 3'h2};
    foreach (am[k]) begin
      wr(`ASP_IDX_ASYNC_MODE, am[k]);
      peer.send(tx[k], nb[k]);
      if (k == 4) begin
        peer.send(12'h122, 9);
      end
      rdc(`ASP_IDX_RX_ERR, {5'h00, xe[k]});
      rdc(`ASP_IDX_RX_DATA, xd[k]);
      wr(`ASP_IDX_ASYNC_MODE, 8'h00);
    end
  endtask

  // width of the high data bit of 0x01 at every prescale code
  task automatic test_baud();
    int w;
    for (int c = 0; c < 9; c++) begin
      wr(`ASP_IDX_BAUD_DIV, 8'(c << 4));
      ext_on <= (c == 8);
      wr(`ASP_IDX_ASYNC_MODE, 8'h88);
      wr(`ASP_IDX_TX_DATA, 8'h01);
      wait_txd(1'b0);
      wait_txd(1'b1);
      w = 0;
      while (pins_out.txd === 1'b1) begin
        @(posedge core_clk);
        w++;
      end
      check(32'(w), (c == 8) ? 32'h0000_0280 : 32'(32 << c));
      wr(`ASP_IDX_ASYNC_MODE, 8'h00);
    end
    ext_on <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    test_modes();
    test_tx();
    test_rx();
    test_baud();
    print_verdict();
  end

  // about 22k cycles expected; a hang ends the run here
  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end
endmodule // tb_async_serial_port_baud_and_modes
